// *** rtl/tbd_decoder.sv ***
// texture block decoder: one 128-bit block plus texel number in, one ARGB texel out
// assumes the sampler presents a request with a valid strobe; answer one cycle later
//
// What this block does
// - Top bits 127:126 equal 00 select the two-base interpolating mode.
// - Interpolating base colour 1 at bits 125:111, colour 0 at 110:96.
// - Interpolating index is three bits, texel n at bits 3n+2:3n.
// - Each 5-bit channel widens to 8 by repeating its three top bits.
// - Entries 0..6 are ((6-k)*c0 + k*c1 + 3)/6 per channel, alpha ff.
// - Interpolating entry 7 is transparent black, all zero.
// - Interpolating output is the 32-bit ARGB entry the 3-bit index picks.
// - Bits 127:125 equal 010 select direct mode; bit 124 ignored.
// - Direct mode holds four 5-5-5 colours, colour 0 lowest at 78:64.
// - Direct index is two bits, texel n at bits 2n+1:2n.
// - All four direct colours widen by top-bit replication.
// - Direct index k picks colour k unblended, alpha always ff.
// - Split-pair uses colours 0,1 for texels 0-15, colours 2,3 for 16-31.
// - Split-pair pairs build own 4-entry tables, 2-bit index, alpha ff.
// - A block covers two 4x4 groups, texels 0-15 then 16-31.
// - Bit 127 set selects split-pair mode regardless of bits 126:125.
`timescale 1ns/100ps
module tbd_decoder
    import tbd_pkg::*;
#(
    parameter int BLOCK_BITS = BLOCK_W
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // request from the sampler
    input wire logic req_valid_in,
    input wire logic [BLOCK_W-1:0] block_128bit_in,
    input wire logic [TEXEL_NUM_W-1:0] texel_num_in,
    // decoded texel
    output logic texel_valid_out,
    output logic [TEXEL_W-1:0] texel_out,
    output logic unsupported_out
);

    // refused at elaboration: the field layout is fixed to one block width
    if (BLOCK_BITS != BLOCK_W) begin : g_bad_block_bits
        $error("tbd_decoder serves only 128-bit blocks");
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wire bit_top = block_128bit_in[MODE_TOP_BIT];
    wire bit_mid = block_128bit_in[MODE_MID_BIT];
    wire bit_low = block_128bit_in[MODE_LOW_BIT];
    tbd_mode_t mode;

    always_comb begin
        case ({bit_top, bit_mid, bit_low})
            3'b000, 3'b001: mode = TBD_MODE_INTERP;
            3'b010: mode = TBD_MODE_DIRECT;
            3'b011: mode = TBD_MODE_ALPHA;
            3'b100, 3'b101, 3'b110, 3'b111: mode = TBD_MODE_SPLIT;
            default: mode = TBD_MODE_ALPHA;
        endcase
    end

    // ------------------------------------------------------------
    // colour extraction and widening
    // ------------------------------------------------------------
    wire [RGB_W-1:0] interp_c0 = rgb_at(block_128bit_in, INTERP_C0_LSB);
    wire [RGB_W-1:0] interp_c1 = rgb_at(block_128bit_in, INTERP_C1_LSB);
    logic [RGB_W-1:0] quad_rgb [DIRECT_COLORS];

    for (genvar k = 0; k < DIRECT_COLORS; k++) begin : g_quad
        // bit 124 lies above colour 3; only interpolating colour 1 reads it
        assign quad_rgb[k] = rgb_at(block_128bit_in,
                                    DIRECT_C0_LSB + k * COLOR_STRIDE);
    end

    // ------------------------------------------------------------
    // texel index selection
    // ------------------------------------------------------------
    wire [IDX3_W-1:0] idx3 = block_128bit_in[int'(texel_num_in) * IDX3_W +: IDX3_W];
    wire [IDX2_W-1:0] idx2 = block_128bit_in[int'(texel_num_in) * IDX2_W +: IDX2_W];
    // texel number msb picks the second 4x4 group
    wire upper_group = texel_num_in[TEXEL_NUM_W-1];

    wire [RGB_W-1:0] split_a = upper_group ? quad_rgb[2] : quad_rgb[0];
    wire [RGB_W-1:0] split_b = upper_group ? quad_rgb[3] : quad_rgb[1];

    // ------------------------------------------------------------
    // blend operands
    // ------------------------------------------------------------
    wire is_split = (mode == TBD_MODE_SPLIT);
    wire [2:0] idx2_w = {1'b0, idx2};
    wire [RGB_W-1:0] blend_a = is_split ? split_a : interp_c0;
    wire [RGB_W-1:0] blend_b = is_split ? split_b : interp_c1;
    wire [2:0] weight_b = is_split ? idx2_w : idx3;
    wire [2:0] weight_a = is_split ? (SPLIT_STEPS - idx2_w) : (INTERP_STEPS - idx3);
    wire [2:0] bias = is_split ? SPLIT_BIAS : INTERP_BIAS;
    wire [RGB_W-1:0] blend_rgb;

    for (genvar ch = 0; ch < 3; ch++) begin : g_chan
        tbd_lerp_if lif ();
        assign lif.c0 = blend_a[ch*8 +: 8];
        assign lif.c1 = blend_b[ch*8 +: 8];
        assign lif.w0 = weight_a;
        assign lif.w1 = weight_b;
        assign lif.bias = bias;
        assign lif.div_sixths = !is_split;
        assign blend_rgb[ch*8 +: 8] = lif.result;
        tbd_lerp_ch u_lerp (
            .lp(lif)
        );
    end

    // ------------------------------------------------------------
    // texel selection per mode
    // ------------------------------------------------------------
    wire [TEXEL_W-1:0] interp_texel = (idx3 == INTERP_TRANSPARENT) ? TEXEL_CLEAR
                                    : {ALPHA_OPAQUE, blend_rgb};
    wire [TEXEL_W-1:0] direct_texel = {ALPHA_OPAQUE, quad_rgb[idx2]};
    wire [TEXEL_W-1:0] split_texel = {ALPHA_OPAQUE, blend_rgb};
    logic [TEXEL_W-1:0] texel_sel;

    always_comb begin
        case (mode)
            TBD_MODE_INTERP: texel_sel = interp_texel;
            TBD_MODE_DIRECT: texel_sel = direct_texel;
            TBD_MODE_SPLIT: texel_sel = split_texel;
            default: texel_sel = TEXEL_CLEAR;
        endcase
    end

    // ------------------------------------------------------------
    // output stage, one cycle of latency
    // ------------------------------------------------------------
    logic valid_reg;
    logic [TEXEL_W-1:0] texel_reg;
    logic unsup_reg;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            valid_reg <= 1'b0;
            texel_reg <= TEXEL_CLEAR;
            unsup_reg <= 1'b0;
        end else begin
            valid_reg <= req_valid_in;
            if (req_valid_in) begin
                texel_reg <= texel_sel;
                unsup_reg <= (mode == TBD_MODE_ALPHA);
            end
        end
    end

    assign texel_valid_out = valid_reg;
    assign texel_out = texel_reg;
    assign unsupported_out = unsup_reg;

endmodule : tbd_decoder

// *** rtl/tbd_pkg.sv ***
// constants, mode encoding and colour helpers for the texture block decoder
// assumes 128-bit blocks holding two 4x4 groups of texels
package tbd_pkg;

    // ------------------------------------------------------------
    // block geometry
    // ------------------------------------------------------------
    localparam int BLOCK_W = 128;
    localparam int TEXELS = 32;
    localparam int TEXEL_NUM_W = 5;
    localparam int TEXEL_W = 32;
    localparam int HALF_TEXELS = 16;
    localparam int MODE_TOP_BIT = 127;
    localparam int MODE_MID_BIT = 126;
    localparam int MODE_LOW_BIT = 125;

    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    localparam int CH_W = 5;
    localparam int RGB_W = 24;
    localparam int RED_OFS = 10;
    localparam int GREEN_OFS = 5;
    localparam int BLUE_OFS = 0;
    localparam int INTERP_C0_LSB = 96;
    localparam int INTERP_C1_LSB = 111;
    localparam int DIRECT_C0_LSB = 64;
    localparam int COLOR_STRIDE = 15;
    localparam int DIRECT_COLORS = 4;
    localparam int IDX3_W = 3;
    localparam int IDX2_W = 2;

    // ------------------------------------------------------------
    // table values
    // ------------------------------------------------------------
    localparam logic [7:0] ALPHA_OPAQUE = 8'hff;
    localparam logic [TEXEL_W-1:0] TEXEL_CLEAR = 32'h0000_0000;
    localparam logic [2:0] INTERP_TRANSPARENT = 3'h7;
    localparam logic [2:0] INTERP_STEPS = 3'h6;
    localparam logic [2:0] INTERP_BIAS = 3'h3;
    localparam logic [2:0] SPLIT_STEPS = 3'h3;
    localparam logic [2:0] SPLIT_BIAS = 3'h1;
    localparam int LERP_SUM_W = 11;
    localparam logic [LERP_SUM_W-1:0] DIV_SIXTHS = 11'h006;
    localparam logic [LERP_SUM_W-1:0] DIV_THIRDS = 11'h003;

    typedef enum logic [1:0] {
        TBD_MODE_INTERP = 2'b00,
        TBD_MODE_DIRECT = 2'b01,
        TBD_MODE_SPLIT = 2'b11,
        TBD_MODE_ALPHA = 2'b10
    } tbd_mode_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] expand5(input logic [CH_W-1:0] f);
        return {f, f[CH_W-1:CH_W-3]};
    endfunction : expand5

    function automatic logic [RGB_W-1:0] rgb_at(input logic [BLOCK_W-1:0] blk,
                                                input int lsb);
        return {expand5(blk[lsb+RED_OFS +: CH_W]),
                expand5(blk[lsb+GREEN_OFS +: CH_W]),
                expand5(blk[lsb+BLUE_OFS +: CH_W])};
    endfunction : rgb_at

endpackage : tbd_pkg

// *** rtl/tbd_lerp_if.sv ***
// carrier between the decoder and its per-channel interpolator
// assumes one instance per 8-bit colour channel
`timescale 1ns/100ps
interface tbd_lerp_if;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [2:0] w0;
    logic [2:0] w1;
    logic [2:0] bias;
    logic div_sixths;
    logic [7:0] result;

    modport requester (output c0, output c1, output w0, output w1, output bias,
                       output div_sixths, input result);
    modport lerp (input c0, input c1, input w0, input w1, input bias,
                  input div_sixths, output result);
endinterface : tbd_lerp_if

// *** rtl/tbd_lerp_ch.sv ***
// one channel of weighted blend with rounding bias and truncating divide
// assumes weights sum to the divisor, so the quotient fits 8 bits
`timescale 1ns/100ps
module tbd_lerp_ch
    import tbd_pkg::*;
(
    // blend operands and result
    tbd_lerp_if.lerp lp
);

    wire [LERP_SUM_W-1:0] sum;
    wire [LERP_SUM_W-1:0] quot;

    assign sum = LERP_SUM_W'(lp.w0) * LERP_SUM_W'(lp.c0)
               + LERP_SUM_W'(lp.w1) * LERP_SUM_W'(lp.c1)
               + LERP_SUM_W'(lp.bias);
    // unsigned, truncating, per channel
    assign quot = lp.div_sixths ? (sum / DIV_SIXTHS) : (sum / DIV_THIRDS);
    assign lp.result = quot[7:0];

endmodule : tbd_lerp_ch

// *** test/tbd_decoder_assertions.sv ***
// port checker for the texture block decoder
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module tbd_decoder_assertions
    import tbd_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire logic [BLOCK_W-1:0] block_128bit_in,
    input wire logic [TEXEL_NUM_W-1:0] texel_num_in,
    input wire logic texel_valid_out,
    input wire logic [TEXEL_W-1:0] texel_out,
    input wire logic unsupported_out
);
    // ----------
    // properties
    // ----------
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    wire logic [2:0] idx3 = block_128bit_in[3*texel_num_in +: 3];
    wire logic [1:0] idx2 = block_128bit_in[2*texel_num_in +: 2];
    wire logic [4:0] dir_red = block_128bit_in[74+15*idx2 +: 5];
    wire logic interp = req_valid_in && block_128bit_in[127:126] == 2'h0;
    wire logic direct = req_valid_in && block_128bit_in[127:125] == 3'h2;
    a_answer_latency: assert property (req_valid_in |=> texel_valid_out)
        else $error("answer missing after request");
    a_no_extra_answer: assert property (!req_valid_in |=> !texel_valid_out)
        else $error("answer without request");
    a_interp_clear: assert property (interp && idx3 == 3'h7 |=> texel_out == 32'h0)
        else $error("entry seven not transparent black");
    a_interp_opaque: assert property (interp && idx3 != 3'h7 |=> texel_out[31:24] == 8'hff)
        else $error("interpolated alpha not opaque");
    a_interp_base0: assert property (interp && idx3 == 3'h0 |=>
        texel_out[23:16] == {$past(block_128bit_in[110:106]), $past(block_128bit_in[110:108])})
        else $error("entry zero red wrong");
    a_interp_base1: assert property (interp && idx3 == 3'h6 |=>
        texel_out[7:0] == {$past(block_128bit_in[115:111]), $past(block_128bit_in[115:113])})
        else $error("entry six blue wrong");
    a_direct_pick: assert property (direct |=>
        texel_out[31:19] == {8'hff, $past(dir_red)})
        else $error("direct lookup wrong");
    a_split_opaque: assert property (req_valid_in && block_128bit_in[127] |=>
        texel_out[31:24] == 8'hff && !unsupported_out)
        else $error("split answer wrong");
endmodule : tbd_decoder_assertions

bind tbd_decoder tbd_decoder_assertions u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .req_valid_in(req_valid_in), .block_128bit_in(block_128bit_in),
    .texel_num_in(texel_num_in), .texel_valid_out(texel_valid_out),
    .texel_out(texel_out), .unsupported_out(unsupported_out));

// *** test/tbd_sampler_model.sv ***
// sampler model: one request per call, scrambled data when idle
// assumes requests change at the falling clock edge
`timescale 1ns/100ps
module tbd_sampler_model
    import tbd_pkg::*;
(
    input wire logic sys_clk_in,
    output logic req_valid_out,
    output logic [BLOCK_W-1:0] block_out,
    output logic [TEXEL_NUM_W-1:0] texel_num_out
);
    // ----------
    // requests
    // ----------
    initial begin
        req_valid_out = 1'b0;
        block_out = '0;
        texel_num_out = '0;
    end
    task automatic request(input logic [BLOCK_W-1:0] blk, input int n);
        @(negedge sys_clk_in);
        req_valid_out = 1'b1;
        block_out = blk;
        texel_num_out = n[TEXEL_NUM_W-1:0];
    endtask : request
    task automatic idle();
        @(negedge sys_clk_in);
        req_valid_out = 1'b0;
        block_out = ~block_out;
        texel_num_out = ~texel_num_out;
    endtask : idle
endmodule : tbd_sampler_model

// *** test/tbd_decoder_tb.sv ***
// self-checking bench for the texture block decoder
// assumes the sampler model drives all requests
`timescale 1ns/100ps
module tbd_decoder_tb;
    import tbd_pkg::*;
    // ----------
    // bench
    // ----------
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid;
    logic [BLOCK_W-1:0] blk;
    logic [TEXEL_NUM_W-1:0] num;
    logic texel_valid_out;
    logic [TEXEL_W-1:0] texel_out;
    logic unsupported_out;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    initial forever #4 sys_clk_in = ~sys_clk_in;
    tbd_sampler_model u_smp (.sys_clk_in(sys_clk_in), .req_valid_out(req_valid),
        .block_out(blk), .texel_num_out(num));
    tbd_decoder u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_valid_in(req_valid),
        .block_128bit_in(blk), .texel_num_in(num), .texel_valid_out(texel_valid_out),
        .texel_out(texel_out), .unsupported_out(unsupported_out));
    function automatic logic [7:0] x5(input logic [4:0] f);
        return {f, f[4:2]};
    endfunction : x5
    function automatic logic [23:0] rgb(input logic [127:0] b, input int lsb);
        return {x5(b[lsb+10 +: 5]), x5(b[lsb+5 +: 5]), x5(b[lsb +: 5])};
    endfunction : rgb
    function automatic logic [32:0] expect_texel(input logic [127:0] b, input int n);
        logic [23:0] a;
        logic [23:0] c;
        logic [31:0] t;
        int k;
        int lo;
        int d;
        int bias;
        k = b[3*n +: 3];
        lo = 96;
        d = 6;
        bias = 3;
        if (b[127]) begin
            k = b[2*n +: 2];
            lo = n < 16 ? 64 : 94;
            d = 3;
            bias = 1;
        end else if (b[126:125] == 2'h3) return {1'b1, 32'h0};
        else if (b[126]) return {1'b0, 8'hff, rgb(b, 64 + 15 * b[2*n +: 2])};
        else if (k == 7) return 33'h0;
        a = rgb(b, lo);
        c = rgb(b, lo + 15);
        t[31:24] = 8'hff;
        for (int ch = 0; ch < 3; ch++) begin
            t[8*ch +: 8] = 8'(((d-k)*a[8*ch +: 8] + k*c[8*ch +: 8] + bias) / d);
        end
        return {1'b0, t};
    endfunction : expect_texel
    function automatic logic [127:0] fill(input logic [63:0] top, input int w);
        logic [127:0] b;
        b = {top, 64'h9e37_79b9_7f4a_7c15};
        for (int n = 0; n < 32; n++) for (int j = 0; j < w; j++) b[w*n+j] = n[j];
        return b;
    endfunction : fill
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic ask(input logic [127:0] b, input int n);
        logic [33:0] seen;
        u_smp.request(b, n);
        @(posedge sys_clk_in);
        #1;
        seen = {texel_valid_out, unsupported_out, texel_out};
        check("texel", seen, {1'b1, expect_texel(b, n)});
    endtask : ask
    task automatic run_block(input logic [63:0] top, input int w);
        logic [127:0] b;
        logic [33:0] seen;
        b = fill(top, w);
        for (int n = 0; n < 32; n++) ask(b, n);
        u_smp.idle();
        @(posedge sys_clk_in);
        #1;
        // valid drops while the last answer stays on the data outputs
        seen = {texel_valid_out, unsupported_out, texel_out};
        check("idle hold", seen, {1'b0, expect_texel(b, 31)});
    endtask : run_block
    task automatic test_interp();
        run_block(64'h2b5e_93c7_d1a4_6f08, 3);
        run_block(64'h1f8c_057a_e3b2_4d91, 3);
    endtask : test_interp
    task automatic test_direct();
        run_block(64'h4f3a_6d91_c28e_57b3, 2);
        run_block(64'h5c91_e2a4_7d36_08f5, 2);
    endtask : test_direct
    task automatic test_split();
        run_block(64'h8d3c_a2f1_5e67_b049, 2);
        run_block(64'ha7e2_19cd_4b80_f36e, 2);
        run_block(64'hc41b_8e5f_d2a9_7063, 2);
        run_block(64'he96d_30b7_1ac4_5f82, 2);
        run_block(64'h6a5d_c3e8_b172_94f0, 2);
    endtask : test_split
    task automatic test_reset();
        u_smp.request(fill(64'h2b5e_93c7_d1a4_6f08, 3), 5);
        rst_in = 1'b1;
        @(posedge sys_clk_in);
        #1;
        check("reset", {texel_valid_out, unsupported_out, texel_out}, 34'h0);
        @(negedge sys_clk_in);
        rst_in = 1'b0;
        @(posedge sys_clk_in);
        #1;
        check("after reset", {texel_valid_out, 33'h0}, {1'b1, 33'h0});
    endtask : test_reset
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(negedge sys_clk_in);
        rst_in = 1'b0;
        test_interp();
        test_direct();
        test_split();
        test_reset();
        report_and_stop();
    end
endmodule : tbd_decoder_tb
